// ### rtl/synth_div_regs.svh
// Register offsets, field positions and reset values of the divider and output slice
`ifndef SYNTH_DIV_REGS_SVH
`define SYNTH_DIV_REGS_SVH

`define SDR_ADDR_XO_LOW       8'h11
`define SDR_ADDR_DRV_CTL      8'h15
`define SDR_ADDR_ODIV_UPPER   8'h16
`define SDR_ADDR_ODIV_LOWER   8'h17
`define SDR_ADDR_RDIV_CTL     8'h18
`define SDR_ADDR_NDIV_UPPER   8'h19
`define SDR_ADDR_NDIV_LOWER   8'h1A
`define SDR_ADDR_NUM_HIGH     8'h1B
`define SDR_ADDR_NUM_MID      8'h1C
`define SDR_ADDR_NUM_LOW      8'h1D
`define SDR_ADDR_DEN_HIGH     8'h1E
`define SDR_ADDR_DEN_MID      8'h1F
`define SDR_ADDR_DEN_LOW      8'h20

`define SDR_PD_BIT            7
`define SDR_DRV_SEL_MSB       1
`define SDR_DRV_SEL_LSB       0
`define SDR_ODIV_MSB_BIT      0
`define SDR_RDIV_BIT          0
`define SDR_NDIV_UP_MSB       3
`define SDR_FRAC_HI_MSB       5

`define SDR_RST_PD            1'h0
`define SDR_RST_DRV_SEL       2'h2
`define SDR_RST_ODIV_UPPER    1'h0
`define SDR_RST_ODIV_LOWER    8'h4E
`define SDR_RST_RDIV          1'h1
`define SDR_RST_NDIV_UPPER    4'h0
`define SDR_RST_NDIV_LOWER    8'hDC
`define SDR_RST_NUM_HIGH      6'h1C
`define SDR_RST_NUM_MID       8'hB3
`define SDR_RST_NUM_LOW       8'hE3
`define SDR_RST_DEN_HIGH      6'h3F
`define SDR_RST_DEN_MID       8'hFF
`define SDR_RST_DEN_LOW       8'hFF
`define SDR_RST_XO_LOW        8'h00

`define SDR_ODIV_MIN          9'h005

`endif

// ### rtl/synth_div_pkg.sv
// Types shared by the divider and output register slice
`default_nettype none

package synth_div_pkg;

   typedef enum logic [1:0] {
      DRV_TRISTATE = 2'h0,
      DRV_LVPECL   = 2'h1,
      DRV_LVDS     = 2'h2,
      DRV_HCSL     = 2'h3
   } drv_format_e;

   // Settings held in the start-up image; powerdown is not among them
   typedef struct packed {
      drv_format_e  drv_sel;
      logic [8:0]   out_div;
      logic         ref_predivide_select;
      logic [11:0]  feedback_integer_value;
      logic [21:0]  fraction_numerator;
      logic [21:0]  fraction_denominator;
      logic [7:0]   crystal_margin_offset_low;
   } synth_image_s;

   // Settings driven to the synthesizer
   typedef struct packed {
      logic         diff_buffer_powerdown;
      drv_format_e  drv_sel;
      logic [8:0]   out_div;
      logic         ref_predivide_select;
      logic [11:0]  feedback_integer_value;
      logic [21:0]  fraction_numerator;
      logic [21:0]  fraction_denominator;
   } synth_cfg_s;

endpackage : synth_div_pkg

`default_nettype wire

// ### rtl/synth_divider_output_regs.sv
// Divider and output configuration registers of the clock synthesizer
`include "synth_div_regs.svh"
`default_nettype none
// How it works
// RL1 - Bit 7 of output control powers the buffer down; resets 0, never loaded from image.
// RL2 - Bits 1:0 pick tri-state, LVPECL, LVDS or HCSL; reset LVDS, held in image.
// RL3 - Nine-bit output divide: upper register bit 0 is MSB, lower register low byte.
// RL4 - Host writes output divide only 5 to 511; 0 to 4 are reserved.
// RL5 - Output divide resets to upper bit 0, lower byte 0x4E, both in image.
// RL6 - Predivide select 1 divides reference by four, 0 bypasses; resets to 1.
// RL7 - Twelve-bit feedback integer: upper nibble bits 11:8, lower byte bits 7:0.
// RL8 - Feedback integer resets to nibble 0x0 and byte 0xDC, restored from image.
// RL9 - Numerator bits 21:16 from high low six bits, then mid, then low byte.
// RL10 - Numerator resets to 0x1C, 0xB3, 0xE3, all held in image.
// RL11 - In tuned-oscillator use host writes numerator high, mid, then low.
// RL12 - Denominator bits 21:16 in low six bits of its high register; reset 0x3F.
// RL13 - Denominator bits 15:8 and 7:0 in two byte registers, each reset 0xFF.
// RL14 - New numerator reaches the synthesizer as one update when low byte written.

module synth_divider_output_regs
   import synth_div_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         arst_n,
   input  wire logic         clk_en,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   output logic      [7:0]   reg_rdata,
   output logic              reg_rvalid,
   output logic              reg_miss,
   input  wire logic         image_load,
   input  wire synth_image_s image_data,
   output synth_cfg_s        cfg,
   output logic      [7:0]   crystal_margin_offset_low,
   output logic              out_div_reserved
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic hit;

   always_comb begin
      case (reg_addr)
         `SDR_ADDR_XO_LOW, `SDR_ADDR_DRV_CTL, `SDR_ADDR_ODIV_UPPER, `SDR_ADDR_ODIV_LOWER,
         `SDR_ADDR_RDIV_CTL, `SDR_ADDR_NDIV_UPPER, `SDR_ADDR_NDIV_LOWER, `SDR_ADDR_NUM_HIGH,
         `SDR_ADDR_NUM_MID, `SDR_ADDR_NUM_LOW, `SDR_ADDR_DEN_HIGH, `SDR_ADDR_DEN_MID,
         `SDR_ADDR_DEN_LOW: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   logic wr_ok;
   assign wr_ok = clk_en && reg_wr && !image_load;

   ////////////////////////////////////////////////////////////////////////////
   // Output buffer control

   logic        pd_r;
   drv_format_e drv_sel_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pd_r <= `SDR_RST_PD;
      end else if (wr_ok && reg_addr == `SDR_ADDR_DRV_CTL) begin
         pd_r <= reg_wdata[`SDR_PD_BIT]; // RL1
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         drv_sel_r <= drv_format_e'(`SDR_RST_DRV_SEL); // RL2
      end else if (clk_en && image_load) begin
         drv_sel_r <= image_data.drv_sel; // RL2
      end else if (wr_ok && reg_addr == `SDR_ADDR_DRV_CTL) begin
         drv_sel_r <= drv_format_e'(reg_wdata[`SDR_DRV_SEL_MSB:`SDR_DRV_SEL_LSB]); // RL2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output divider and reference predivider

   logic       odiv_up_r;
   logic [7:0] odiv_lo_r;
   logic       rdiv_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         odiv_up_r <= `SDR_RST_ODIV_UPPER; // RL5
         odiv_lo_r <= `SDR_RST_ODIV_LOWER; // RL5
      end else if (clk_en && image_load) begin
         odiv_up_r <= image_data.out_div[8]; // RL5
         odiv_lo_r <= image_data.out_div[7:0];
      end else if (wr_ok) begin
         if (reg_addr == `SDR_ADDR_ODIV_UPPER) begin
            odiv_up_r <= reg_wdata[`SDR_ODIV_MSB_BIT]; // RL3
         end
         if (reg_addr == `SDR_ADDR_ODIV_LOWER) begin
            odiv_lo_r <= reg_wdata; // RL3
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdiv_r <= `SDR_RST_RDIV; // RL6
      end else if (clk_en && image_load) begin
         rdiv_r <= image_data.ref_predivide_select;
      end else if (wr_ok && reg_addr == `SDR_ADDR_RDIV_CTL) begin
         rdiv_r <= reg_wdata[`SDR_RDIV_BIT]; // RL6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feedback integer divider

   logic [3:0] ndiv_up_r;
   logic [7:0] ndiv_lo_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ndiv_up_r <= `SDR_RST_NDIV_UPPER; // RL8
         ndiv_lo_r <= `SDR_RST_NDIV_LOWER; // RL8
      end else if (clk_en && image_load) begin
         ndiv_up_r <= image_data.feedback_integer_value[11:8]; // RL8
         ndiv_lo_r <= image_data.feedback_integer_value[7:0];
      end else if (wr_ok) begin
         if (reg_addr == `SDR_ADDR_NDIV_UPPER) begin
            ndiv_up_r <= reg_wdata[`SDR_NDIV_UP_MSB:0]; // RL7
         end
         if (reg_addr == `SDR_ADDR_NDIV_LOWER) begin
            ndiv_lo_r <= reg_wdata; // RL7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fractional numerator: staged bytes, applied word

   // High and mid bytes wait in staging so a half-written value never steers the loop
   logic [5:0]  num_hi_r;
   logic [7:0]  num_mid_r;
   logic [7:0]  num_lo_r;
   logic [21:0] num_apply_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         num_hi_r  <= `SDR_RST_NUM_HIGH; // RL10
         num_mid_r <= `SDR_RST_NUM_MID; // RL10
         num_lo_r  <= `SDR_RST_NUM_LOW; // RL10
      end else if (clk_en && image_load) begin
         num_hi_r  <= image_data.fraction_numerator[21:16];
         num_mid_r <= image_data.fraction_numerator[15:8];
         num_lo_r  <= image_data.fraction_numerator[7:0];
      end else if (wr_ok) begin
         if (reg_addr == `SDR_ADDR_NUM_HIGH) begin
            num_hi_r <= reg_wdata[`SDR_FRAC_HI_MSB:0]; // RL9
         end
         if (reg_addr == `SDR_ADDR_NUM_MID) begin
            num_mid_r <= reg_wdata; // RL9
         end
         if (reg_addr == `SDR_ADDR_NUM_LOW) begin
            num_lo_r <= reg_wdata; // RL9
         end
      end
   end

   // Relies on the host ordering high, mid, low for a glitch-free step
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         num_apply_r <= {`SDR_RST_NUM_HIGH, `SDR_RST_NUM_MID, `SDR_RST_NUM_LOW}; // RL10
      end else if (clk_en && image_load) begin
         num_apply_r <= image_data.fraction_numerator;
      end else if (wr_ok && reg_addr == `SDR_ADDR_NUM_LOW) begin
         num_apply_r <= {num_hi_r, num_mid_r, reg_wdata}; // RL14 RL11
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fractional denominator and crystal margin byte

   logic [5:0] den_hi_r;
   logic [7:0] den_mid_r;
   logic [7:0] den_lo_r;
   logic [7:0] xo_lo_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         den_hi_r  <= `SDR_RST_DEN_HIGH; // RL12
         den_mid_r <= `SDR_RST_DEN_MID; // RL13
         den_lo_r  <= `SDR_RST_DEN_LOW; // RL13
      end else if (clk_en && image_load) begin
         den_hi_r  <= image_data.fraction_denominator[21:16]; // RL12
         den_mid_r <= image_data.fraction_denominator[15:8]; // RL13
         den_lo_r  <= image_data.fraction_denominator[7:0];
      end else if (wr_ok) begin
         if (reg_addr == `SDR_ADDR_DEN_HIGH) begin
            den_hi_r <= reg_wdata[`SDR_FRAC_HI_MSB:0]; // RL12
         end
         if (reg_addr == `SDR_ADDR_DEN_MID) begin
            den_mid_r <= reg_wdata; // RL13
         end
         if (reg_addr == `SDR_ADDR_DEN_LOW) begin
            den_lo_r <= reg_wdata; // RL13
         end
      end
   end

   // Reserved to the host: loaded from the image only, writes ignored
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         xo_lo_r <= `SDR_RST_XO_LOW;
      end else if (clk_en && image_load) begin
         xo_lo_r <= image_data.crystal_margin_offset_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, one cycle latency, reserved bits read zero

   logic [7:0] rd_nxt;

   always_comb begin
      case (reg_addr)
         `SDR_ADDR_XO_LOW:     rd_nxt = xo_lo_r;
         `SDR_ADDR_DRV_CTL:    rd_nxt = {pd_r, 5'h00, drv_sel_r};
         `SDR_ADDR_ODIV_UPPER: rd_nxt = {7'h00, odiv_up_r};
         `SDR_ADDR_ODIV_LOWER: rd_nxt = odiv_lo_r;
         `SDR_ADDR_RDIV_CTL:   rd_nxt = {7'h00, rdiv_r};
         `SDR_ADDR_NDIV_UPPER: rd_nxt = {4'h0, ndiv_up_r};
         `SDR_ADDR_NDIV_LOWER: rd_nxt = ndiv_lo_r;
         `SDR_ADDR_NUM_HIGH:   rd_nxt = {2'h0, num_hi_r};
         `SDR_ADDR_NUM_MID:    rd_nxt = num_mid_r;
         `SDR_ADDR_NUM_LOW:    rd_nxt = num_lo_r;
         `SDR_ADDR_DEN_HIGH:   rd_nxt = {2'h0, den_hi_r};
         `SDR_ADDR_DEN_MID:    rd_nxt = den_mid_r;
         `SDR_ADDR_DEN_LOW:    rd_nxt = den_lo_r;
         default:              rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
         reg_miss   <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= reg_rd;
         reg_miss   <= (reg_rd || reg_wr) && !hit;
         if (reg_rd) begin
            reg_rdata <= rd_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings to the synthesizer

   always_comb begin
      cfg.diff_buffer_powerdown  = pd_r; // RL1
      cfg.drv_sel                = drv_sel_r; // RL2
      cfg.out_div                = {odiv_up_r, odiv_lo_r}; // RL3
      cfg.ref_predivide_select   = rdiv_r; // RL6
      cfg.feedback_integer_value = {ndiv_up_r, ndiv_lo_r}; // RL7
      cfg.fraction_numerator     = num_apply_r; // RL14
      cfg.fraction_denominator   = {den_hi_r, den_mid_r, den_lo_r}; // RL12 RL13
   end

   assign crystal_margin_offset_low = xo_lo_r;
   // Flag only; a reserved divide value is still passed on as written
   assign out_div_reserved = ({odiv_up_r, odiv_lo_r} < `SDR_ODIV_MIN); // RL4

endmodule : synth_divider_output_regs

`default_nettype wire

// ### sim/synth_div_regs_properties.sv
// Concurrent checks on the divider and output register slice
`default_nettype none
module synth_div_regs_properties
   import synth_div_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         arst_n,
   input  wire logic         clk_en,
   input  wire logic         reg_wr,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         image_load,
   input  wire synth_image_s image_data,
   input  wire synth_cfg_s   cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   // Load beats write, so a write is only taken without a load
   logic wr_ok;
   assign wr_ok = clk_en && reg_wr && !image_load;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////
   property p_pd; wr_ok && reg_addr == 8'h15 |=> cfg.diff_buffer_powerdown == $past(reg_wdata[7]); endproperty
   a_pd: assert property (p_pd) else $error("powerdown bit wrong");
   property p_drv; wr_ok && reg_addr == 8'h15 |=> cfg.drv_sel == $past(reg_wdata[1:0]); endproperty
   a_drv: assert property (p_drv) else $error("driver select wrong");
   property p_odiv; wr_ok && reg_addr == 8'h16 |=> cfg.out_div == {$past(reg_wdata[0]), $past(cfg.out_div[7:0])}; endproperty
   a_odiv: assert property (p_odiv) else $error("output divide msb wrong");
   property p_num_hold; wr_ok && (reg_addr == 8'h1B || reg_addr == 8'h1C) |=> $stable(cfg.fraction_numerator); endproperty
   a_num_hold: assert property (p_num_hold) else $error("numerator moved early");
   property p_num_apply; wr_ok && reg_addr == 8'h1D |=> cfg.fraction_numerator[7:0] == $past(reg_wdata); endproperty
   a_num_apply: assert property (p_num_apply) else $error("numerator not applied");
   property p_den; wr_ok && reg_addr == 8'h1E |=> cfg.fraction_denominator[21:16] == $past(reg_wdata[5:0]); endproperty
   a_den: assert property (p_den) else $error("denominator high wrong");
   property p_img; clk_en && image_load |=> cfg == {$past(cfg[68]), $past(image_data[75:8])}; endproperty
   a_img: assert property (p_img) else $error("image load wrong");
   property p_rst; !$past(arst_n) |-> cfg == {1'b0, DRV_LVDS, 9'h04E, 1'b1, 12'h0DC, 22'h1CB3E3, 22'h3FFFFF}; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   ////////////////////////////////////////////////////////////////
   c_num: cover property (wr_ok && reg_addr == 8'h1D);
   c_img: cover property (clk_en && image_load);
   c_odiv: cover property (wr_ok && reg_addr == 8'h16);
endmodule : synth_div_regs_properties

bind synth_divider_output_regs synth_div_regs_properties u_props (
   .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .image_load(image_load), .image_data(image_data), .cfg(cfg)
);
`default_nettype wire

// ### sim/reg_host_model.sv
// Host model driving the register port of the slice
`default_nettype none
module reg_host_model (
   input  wire logic       clk_sys,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released lines show the inverse, so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask : rd
   // Callers keep the divide within 5 to 511
   task automatic wr_odiv(input logic [8:0] v);
      wr(8'h16, {7'h00, v[8]});
      wr(8'h17, v[7:0]);
   endtask : wr_odiv
   task automatic wr_num(input logic [21:0] n);
      wr(8'h1B, {2'h0, n[21:16]});
      wr(8'h1C, n[15:8]);
      wr(8'h1D, n[7:0]);
   endtask : wr_num
endmodule : reg_host_model
`default_nettype wire

// ### sim/synth_divider_output_regs_bench.sv
// Self-checking bench for the divider and output register slice
`default_nettype none
module synth_divider_output_regs_bench
   import synth_div_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rb;} row_s;
   logic         clk_sys = 1'b0;
   logic         arst_n = 1'b0;
   logic         clk_en = 1'b1;
   logic         image_load = 1'b0;
   logic         reg_wr, reg_rd, reg_rvalid, reg_miss, rd_ok, odiv_rsvd;
   logic [7:0]   reg_addr, reg_wdata, reg_rdata, rd_val, crystal;
   synth_image_s image_data = '0;
   synth_cfg_s   cfg;
   int           err_total = 0;
   int           checked = 0;
   // Reserved bits read back as zero; 0x11 ignores writes
   row_s rows [10] = '{'{8'h15, 8'hFF, 8'h83}, '{8'h16, 8'hFF, 8'h01}, '{8'h17, 8'hA5, 8'hA5},
      '{8'h18, 8'hFE, 8'h00}, '{8'h19, 8'hF7, 8'h07}, '{8'h1A, 8'h3C, 8'h3C}, '{8'h1E, 8'hC9, 8'h09},
      '{8'h1F, 8'h5A, 8'h5A}, '{8'h20, 8'h96, 8'h96}, '{8'h11, 8'h77, 8'h00}};
   always #2 clk_sys = ~clk_sys;
   synth_divider_output_regs uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_miss(reg_miss), .image_load(image_load), .image_data(image_data), .cfg(cfg),
      .crystal_margin_offset_low(crystal), .out_div_reserved(odiv_rsvd)
   );
   reg_host_model u_host (
      .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );
   ////////////////////////////////////////////////////////////////
   // Wide enough for the whole settings word plus the crystal byte
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (2000) @(posedge clk_sys);
      err_total++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clk_sys);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         u_host.wr(rows[i].a, rows[i].d);
         u_host.rd(rows[i].a, rd_val, rd_ok);
         check({rd_ok, reg_miss}, 2'b10);
         check(rd_val, rows[i].rb);
      end
      check(cfg, {1'b1, DRV_HCSL, 9'h1A5, 1'b0, 12'h73C, 22'h1CB3E3, 22'h095A96});
      // Write in the load cycle must be dropped
      image_data = {DRV_LVPECL, 9'h1F0, 1'b1, 12'hABC, 22'h155555, 22'h2AAAAA, 8'h5C};
      fork
         u_host.wr(8'h15, 8'h00);
         begin
            @(negedge clk_sys);
            image_load = 1'b1;
            @(negedge clk_sys);
            image_load = 1'b0;
         end
      join
      check({cfg, crystal}, {1'b1, image_data});
      u_host.wr(8'h1B, 8'hFF);
      u_host.wr(8'h1C, 8'h12);
      check(cfg.fraction_numerator, 22'h155555);
      u_host.rd(8'h1B, rd_val, rd_ok);
      check(rd_val, 8'h3F);
      u_host.wr(8'h1D, 8'h34);
      check(cfg.fraction_numerator, 22'h3F1234);
      u_host.wr_num(22'h2ABCDE);
      check(cfg.fraction_numerator, 22'h2ABCDE);
      for (int k = 0; k < 4; k++) begin
         u_host.wr(8'h15, 8'(k));
         check({cfg.diff_buffer_powerdown, cfg.drv_sel}, {1'b0, k[1:0]});
      end
      u_host.wr(8'h16, 8'h00);
      u_host.wr(8'h17, 8'h04);
      check({odiv_rsvd, cfg.out_div}, {1'b1, 9'h004});
      u_host.wr_odiv(9'h105);
      check({odiv_rsvd, cfg.out_div}, {1'b0, 9'h105});
      // Enable low freezes everything, so this write must not land
      clk_en = 1'b0;
      u_host.wr(8'h17, 8'h99);
      clk_en = 1'b1;
      check(cfg.out_div, 9'h105);
      u_host.rd(8'h12, rd_val, rd_ok);
      check(rd_val, 8'h00);
      check({rd_ok, reg_miss}, 2'b11);
      // Second reset in mid-run
      arst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      check(cfg, {1'b0, DRV_LVDS, 9'h04E, 1'b1, 12'h0DC, 22'h1CB3E3, 22'h3FFFFF});
      u_host.rd(8'h1D, rd_val, rd_ok);
      check(rd_val, 8'hE3);
      final_report();
   end
endmodule : synth_divider_output_regs_bench
`default_nettype wire
